// File: core/dfs_deformatter_status.sv
// Operation
// - line error on bad or flywheel-mismatched number
// - one bad line number flags two lines
// - SAV error on bad or mismatched SAV
// - EAV error on bad or mismatched EAV
// - luma checksum mismatch raises luma flag
// - chroma checksum mismatch raises chroma flag
// - level 000 underrun, 111 overrun
// - level 001 empty, 010 at 32, 011 ready
// - level 100 half, 101 at 992, 110 full
// - level shows luma when select high
// - aux bus shows luma when select high
// - each rising read clock edge with read enable low advances selected fifo unless empty
// - output enable high floats aux and level
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module dfs_deformatter_status
    import dfs_pkg::*;
#(
    parameter int DEPTH  = FIFO_DEPTH,
    parameter int AEMPTY = ALMOST_EMPTY,
    parameter int AFULL  = ALMOST_FULL
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  dfs_trs_t         trsIn,
    input  dfs_anc_t         lumaAnc,
    input  dfs_anc_t         chromaAnc,
    input  wire logic        channelSelect,
    input  wire logic        fifoResetN,
    input  wire logic        readClock,
    input  wire logic        readEnableN,
    input  wire logic        fifoOutputEnableN,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             lineNumberError,
    output logic             startMarkerError,
    output logic             endMarkerError,
    output logic             lumaChecksumError,
    output logic             chromaChecksumError,
    output logic      [2:0]  fifoLevelCode,
    output logic             fifoLevelCodeOe,
    output logic      [9:0]  auxDataOut,
    output logic             auxDataOutOe,
    output logic             irq
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 4 || (1 << AW) != DEPTH || AEMPTY >= DEPTH / 2 || AFULL <= DEPTH / 2
        || AFULL >= DEPTH) begin : g_bad_geometry
        $error("fifo depth must be a power of two with ordered thresholds");
    end

    function automatic logic [2:0] levelOf(input logic und, input logic ovr,
                                           input logic [AW:0] cnt);
        if (und)                                levelOf = LVL_UNDER;
        else if (ovr)                           levelOf = LVL_OVER;
        else if (cnt == '0)                     levelOf = LVL_EMPTY;
        else if (cnt == (AW+1)'(DEPTH))         levelOf = LVL_FULL;
        else if (cnt >= (AW+1)'(AFULL))         levelOf = LVL_AFULL;
        else if (cnt >= (AW+1)'(DEPTH / 2))     levelOf = LVL_HALF;
        else if (cnt <= (AW+1)'(AEMPTY))        levelOf = LVL_AEMPTY;
        else                                    levelOf = LVL_READY;
    endfunction

    // checksum word: low nine bits are the sum, bit 9 is the inverse of bit 8
    function automatic logic csBad(input logic [8:0] sum, input logic [9:0] w);
        csBad = (w[8:0] != sum) || (w[9] != ~w[8]);
    endfunction

    logic                fwEn_q;
    logic [ST_W-1:0]     status_q;
    logic [ST_W-1:0]     mask_q;
    logic [10:0]         prevLine_q;
    logic                prevValid_q;
    logic [8:0]          sum_q     [2];
    logic [9:0]          mem       [2][DEPTH];
    logic [AW-1:0]       wrPtr_q   [2];
    logic [AW-1:0]       rdPtr_q   [2];
    logic [AW:0]         cnt_q     [2];
    logic                und_q     [2];
    logic                ovr_q     [2];
    logic                rclkMeta_q, rclkSync_q, rclkPrev_q;
    logic                renMeta_q, renSync_q;
    logic                foenMeta_q, foenSync_q;
    dfs_anc_t            anc       [2];
    logic                push      [2];
    logic                pop       [2];
    logic                rdEdge;
    logic                lnBad, savBad, eavBad, ycsBad, ccsBad;
    logic [ST_W-1:0]     events;
    logic                wrAcc;

    assign anc[CH_LUMA]   = lumaAnc;
    assign anc[CH_CHROMA] = chromaAnc;

    // read clock and enables come from outside: two flops before any use
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rclkMeta_q <= 1'b0;
            rclkSync_q <= 1'b0;
            rclkPrev_q <= 1'b0;
            renMeta_q  <= 1'b1;
            renSync_q  <= 1'b1;
            foenMeta_q <= 1'b1;
            foenSync_q <= 1'b1;
        end else begin
            rclkMeta_q <= readClock;
            rclkSync_q <= rclkMeta_q;
            rclkPrev_q <= rclkSync_q;
            renMeta_q  <= readEnableN;
            renSync_q  <= renMeta_q;
            foenMeta_q <= fifoOutputEnableN;
            foenSync_q <= foenMeta_q;
        end
    end

    // read enable is judged at the same sampled edge as the read clock
    assign rdEdge = rclkSync_q & ~rclkPrev_q & ~renSync_q;

    // timing reference and line number checks
    assign lnBad = (prevValid_q && trsIn.lineNum != prevLine_q + 11'h001
                    && trsIn.lineNum != LINE_FIRST)
                   || (fwEn_q && trsIn.lineNum != trsIn.fwLine);
    assign savBad = (trsIn.sav && trsIn.trsBad)
                    || (fwEn_q && (trsIn.sav != trsIn.fwSav));
    assign eavBad = (trsIn.eav && trsIn.trsBad)
                    || (fwEn_q && (trsIn.eav != trsIn.fwEav));

    // the flag compares against the previous number, so one bad number
    // also spoils the next line's comparison and the flag spans two lines
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lineNumberError <= 1'b0;
            prevLine_q      <= '0;
            prevValid_q     <= 1'b0;
        end else if (trsIn.lineStb) begin
            lineNumberError <= lnBad;
            prevLine_q      <= trsIn.lineNum;
            prevValid_q     <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            startMarkerError <= 1'b0;
            endMarkerError   <= 1'b0;
        end else begin
            if (trsIn.sav || (fwEn_q && trsIn.fwSav)) begin
                startMarkerError <= savBad;
            end
            if (trsIn.eav || (fwEn_q && trsIn.fwEav)) begin
                endMarkerError <= eavBad;
            end
        end
    end

    // ancillary checksum: running nine-bit sum up to the checksum word
    assign ycsBad = lumaAnc.valid && lumaAnc.last && csBad(sum_q[CH_LUMA], lumaAnc.word);
    assign ccsBad = chromaAnc.valid && chromaAnc.last
                    && csBad(sum_q[CH_CHROMA], chromaAnc.word);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lumaChecksumError   <= 1'b0;
            chromaChecksumError <= 1'b0;
        end else begin
            if (lumaAnc.valid && lumaAnc.last) begin
                lumaChecksumError <= ycsBad;
            end
            if (chromaAnc.valid && chromaAnc.last) begin
                chromaChecksumError <= ccsBad;
            end
        end
    end

    // fifo pair; a push into a full fifo is dropped and marks overrun
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            push[c] = anc[c].valid && cnt_q[c] != (AW+1)'(DEPTH);
            pop[c]  = rdEdge && (channelSelect == (c == CH_LUMA)) && cnt_q[c] != '0;
        end
    end

    always_ff @(posedge clock) begin
        for (int c = 0; c < 2; c++) begin
            if (push[c]) begin
                mem[c][wrPtr_q[c]] <= anc[c].word;
            end
        end
    end

    always_ff @(posedge clock) begin
        for (int c = 0; c < 2; c++) begin
            if (!rst_n || !fifoResetN) begin
                wrPtr_q[c] <= '0;
                rdPtr_q[c] <= '0;
                cnt_q[c]   <= '0;
                und_q[c]   <= 1'b0;
                ovr_q[c]   <= 1'b0;
                sum_q[c]   <= '0;
            end else begin
                if (push[c]) wrPtr_q[c] <= wrPtr_q[c] + 1'b1;
                if (pop[c]) rdPtr_q[c] <= rdPtr_q[c] + 1'b1;
                if (push[c] && !pop[c]) cnt_q[c] <= cnt_q[c] + 1'b1;
                else if (pop[c] && !push[c]) cnt_q[c] <= cnt_q[c] - 1'b1;
                if (rdEdge && (channelSelect == (c == CH_LUMA)) && cnt_q[c] == '0) begin
                    und_q[c] <= 1'b1;
                end
                if (anc[c].valid && !push[c]) begin
                    ovr_q[c] <= 1'b1;
                end
                if (anc[c].valid) begin
                    sum_q[c] <= anc[c].last ? 9'h000 : sum_q[c] + anc[c].word[8:0];
                end
            end
        end
    end

    // reader side outputs; pointers move whatever the output enable says
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            auxDataOut      <= '0;
            fifoLevelCode   <= LVL_EMPTY;
            auxDataOutOe    <= 1'b0;
            fifoLevelCodeOe <= 1'b0;
        end else begin
            if (pop[CH_LUMA]) auxDataOut <= mem[CH_LUMA][rdPtr_q[CH_LUMA]];
            else if (pop[CH_CHROMA]) auxDataOut <= mem[CH_CHROMA][rdPtr_q[CH_CHROMA]];
            fifoLevelCode <= channelSelect
                ? levelOf(und_q[CH_LUMA], ovr_q[CH_LUMA], cnt_q[CH_LUMA])
                : levelOf(und_q[CH_CHROMA], ovr_q[CH_CHROMA], cnt_q[CH_CHROMA]);
            auxDataOutOe    <= ~foenSync_q;
            fifoLevelCodeOe <= ~foenSync_q;
        end
    end

    // apb slave, one wait state so read data leaves a flop
    assign wrAcc  = psel && penable && pready && pwrite;
    assign events = {ovr_q[CH_LUMA] | ovr_q[CH_CHROMA] | (lumaAnc.valid & ~push[CH_LUMA]),
                     und_q[CH_LUMA] | und_q[CH_CHROMA], ccsBad, ycsBad,
                     endMarkerError, startMarkerError, lineNumberError};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && penable && !pready) begin
                unique case (paddr)
                    CTRL_OFS:   prdata[CTRL_FW_BIT] <= fwEn_q;
                    STATUS_OFS: prdata[ST_W-1:0] <= status_q;
                    MASK_OFS:   prdata[ST_W-1:0] <= mask_q;
                    LEVEL_OFS: begin
                        prdata[LVL_LUMA_LSB+:3] <=
                            levelOf(und_q[CH_LUMA], ovr_q[CH_LUMA], cnt_q[CH_LUMA]);
                        prdata[LVL_CHROMA_LSB+:3] <=
                            levelOf(und_q[CH_CHROMA], ovr_q[CH_CHROMA], cnt_q[CH_CHROMA]);
                    end
                    default:    pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fwEn_q <= CTRL_FW_RST;
            mask_q <= MASK_RST;
        end else if (wrAcc && paddr == CTRL_OFS) begin
            fwEn_q <= pwdata[CTRL_FW_BIT];
        end else if (wrAcc && paddr == MASK_OFS) begin
            mask_q <= pwdata[ST_W-1:0];
        end
    end

    // a new event in the clearing cycle survives the write-one-to-clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~((wrAcc && paddr == STATUS_OFS) ? pwdata[ST_W-1:0] : '0))
                        | events;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) irq <= 1'b0;
        else irq <= |(status_q & mask_q);
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_ln_flywheel: assert property (
        trsIn.lineStb && fwEn_q && trsIn.lineNum != trsIn.fwLine |=> lineNumberError)
        else $error("line mismatch not flagged");
    chk_ln_holds: assert property (!trsIn.lineStb |=> $stable(lineNumberError))
        else $error("line flag moved between line numbers");
    chk_sav_bad: assert property (trsIn.sav && trsIn.trsBad |=> startMarkerError)
        else $error("bad sav not flagged");
    chk_eav_bad: assert property (trsIn.eav && trsIn.trsBad |=> endMarkerError)
        else $error("bad eav not flagged");
    chk_luma_cs: assert property (lumaAnc.valid && lumaAnc.last
        && (lumaAnc.word[8:0] != sum_q[CH_LUMA] || lumaAnc.word[9] == lumaAnc.word[8])
        |=> lumaChecksumError) else $error("luma checksum flag wrong");
    chk_luma_cs_ok: assert property (lumaAnc.valid && lumaAnc.last
        && lumaAnc.word[8:0] == sum_q[CH_LUMA] && lumaAnc.word[9] != lumaAnc.word[8]
        |=> !lumaChecksumError) else $error("good luma checksum flagged");
    chk_chroma_cs: assert property (chromaAnc.valid && chromaAnc.last
        && (chromaAnc.word[8:0] != sum_q[CH_CHROMA] || chromaAnc.word[9] == chromaAnc.word[8])
        |=> chromaChecksumError) else $error("chroma checksum flag wrong");
    chk_level_over: assert property (!channelSelect && ovr_q[CH_CHROMA]
        && !und_q[CH_CHROMA] |=> fifoLevelCode == LVL_OVER)
        else $error("overrun code missing");
    chk_level_empty: assert property (!channelSelect && cnt_q[CH_CHROMA] == '0
        && !und_q[CH_CHROMA] && !ovr_q[CH_CHROMA] |=> fifoLevelCode == LVL_EMPTY)
        else $error("empty code missing");
    chk_level_full: assert property (!channelSelect
        && cnt_q[CH_CHROMA] == (AW+1)'(DEPTH) && !und_q[CH_CHROMA] && !ovr_q[CH_CHROMA]
        |=> fifoLevelCode == LVL_FULL) else $error("full code missing");
    chk_read_step: assert property (pop[CH_LUMA] |=> auxDataOut
        == mem[CH_LUMA][$past(rdPtr_q[CH_LUMA])] && rdPtr_q[CH_LUMA]
        == $past(rdPtr_q[CH_LUMA]) + 1'b1) else $error("luma read did not advance");
    chk_float: assert property (fifoOutputEnableN [*3]
        |=> !auxDataOutOe && !fifoLevelCodeOe) else $error("outputs driven while disabled");
    chk_irq_level: assert property (|(status_q & mask_q) |=> irq)
        else $error("interrupt not raised");

    cov_sav_error: cover property (trsIn.sav && trsIn.trsBad ##1 startMarkerError);
    cov_chroma_full: cover property (cnt_q[CH_CHROMA] == (AW+1)'(DEPTH));
    cov_chroma_pop: cover property (pop[CH_CHROMA]);
    cov_underrun: cover property ($rose(und_q[CH_LUMA]));
endmodule // dfs_deformatter_status

// File: core/dfs_pkg.sv
package dfs_pkg;
    // register byte offsets
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] MASK_OFS   = 12'h008;
    localparam logic [11:0] LEVEL_OFS  = 12'h00C;
    // control fields
    localparam int CTRL_FW_BIT = 0;
    localparam logic CTRL_FW_RST = 1'b0;
    // status / mask layout
    localparam int ST_LN  = 0;
    localparam int ST_SAV = 1;
    localparam int ST_EAV = 2;
    localparam int ST_YCS = 3;
    localparam int ST_CCS = 4;
    localparam int ST_UND = 5;
    localparam int ST_OVR = 6;
    localparam int ST_W   = 7;
    localparam logic [ST_W-1:0] MASK_RST = 7'h00;
    // level register fields
    localparam int LVL_CHROMA_LSB = 0;
    localparam int LVL_LUMA_LSB   = 4;
    // fifo level codes
    localparam logic [2:0] LVL_UNDER  = 3'h0;
    localparam logic [2:0] LVL_EMPTY  = 3'h1;
    localparam logic [2:0] LVL_AEMPTY = 3'h2;
    localparam logic [2:0] LVL_READY  = 3'h3;
    localparam logic [2:0] LVL_HALF   = 3'h4;
    localparam logic [2:0] LVL_AFULL  = 3'h5;
    localparam logic [2:0] LVL_FULL   = 3'h6;
    localparam logic [2:0] LVL_OVER   = 3'h7;
    // fifo geometry, fill thresholds and first line number
    localparam int FIFO_DEPTH   = 1024;
    localparam int ALMOST_EMPTY = 32;
    localparam int ALMOST_FULL  = 992;
    localparam logic [10:0] LINE_FIRST = 11'h001;
    // channel index: select high picks luma
    localparam int CH_CHROMA = 0;
    localparam int CH_LUMA   = 1;

    typedef struct packed {
        logic        sav;
        logic        eav;
        logic        trsBad;
        logic        fwSav;
        logic        fwEav;
        logic        lineStb;
        logic [10:0] lineNum;
        logic [10:0] fwLine;
    } dfs_trs_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [9:0] word;
    } dfs_anc_t;
endpackage

// File: dv/dfs_reader_model.sv
`timescale 1ns/1ps
module dfs_reader_model (
    input  wire logic clock,
    output logic      readClock,
    output logic      readEnableN,
    output logic      fifoOutputEnableN,
    output logic      channelSelect
);
    // idle: read clock parked low, reads blocked, outputs floating
    initial begin
        readClock = 1'b0;
        readEnableN = 1'b1;
        fifoOutputEnableN = 1'b1;
        channelSelect = 1'b1;
    end

    // held four cycles so the 2-flop syncs settle before anyone looks
    task automatic setup(input logic sel, input logic oen);
        @(posedge clock);
        channelSelect <= sel;
        fifoOutputEnableN <= oen;
        repeat (4) @(posedge clock);
    endtask

    // enable leads the clock by three cycles so it is synced when the edge lands
    task automatic pop(input int slow);
        @(posedge clock);
        readEnableN <= 1'b0;
        repeat (3) @(posedge clock);
        readClock <= 1'b1;
        repeat (2 + slow) @(posedge clock);
        readClock <= 1'b0;
        repeat (2 + slow) @(posedge clock);
        readEnableN <= 1'b1;
        repeat (2) @(posedge clock);
    endtask
endmodule // dfs_reader_model

// File: dv/dfs_deformatter_status_bench.sv
`timescale 1ns/1ps
module dfs_deformatter_status_bench
    import dfs_pkg::*;
    ;
    localparam int D  = 64;
    localparam int AE = 4;
    localparam int AF = 60;
    logic        clock      = 1'b0;
    logic        rst_n      = 1'b0;
    logic        fifoResetN = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0;
    dfs_trs_t    trs        = '0;
    dfs_anc_t    luma       = '0;
    dfs_anc_t    chroma     = '0;
    logic [31:0] prdata, rdata;
    logic        pready, pslverr, rerr, lnErr, savErr, eavErr, ycsErr, ccsErr;
    logic        lvlOe, auxOe, irq, readClock, readEnableN, fifoOutputEnableN, channelSelect;
    logic [2:0]  lvl;
    logic [9:0]  aux;
    int          fails      = 0;
    int          checkCount = 0;
    logic [9:0]  lw [6]     = '{10'h001, 10'h002, 10'h003, 10'h206, 10'h005, 10'h105};
    // {sav, eav, bad, fwSav, fwEav, savErr, eavErr}
    logic [6:0]  tbl [7]    = '{7'h48, 7'h0A, 7'h48, 7'h5A, 7'h07, 7'h26, 7'h37};

    always #5 clock = ~clock;

    dfs_deformatter_status #(.DEPTH(D), .AEMPTY(AE), .AFULL(AF)) dut (
        .clock(clock), .rst_n(rst_n), .trsIn(trs), .lumaAnc(luma), .chromaAnc(chroma),
        .channelSelect(channelSelect), .fifoResetN(fifoResetN), .readClock(readClock),
        .readEnableN(readEnableN), .fifoOutputEnableN(fifoOutputEnableN), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lineNumberError(lnErr),
        .startMarkerError(savErr), .endMarkerError(eavErr), .lumaChecksumError(ycsErr),
        .chromaChecksumError(ccsErr), .fifoLevelCode(lvl), .fifoLevelCodeOe(lvlOe),
        .auxDataOut(aux), .auxDataOutOe(auxOe), .irq(irq)
    );

    dfs_reader_model rm (
        .clock(clock), .readClock(readClock), .readEnableN(readEnableN),
        .fifoOutputEnableN(fifoOutputEnableN), .channelSelect(channelSelect)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic endTest(input string name);
        $display("test %s done at %0t", name, $time);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fails++;
            summarize();
        end else begin
            rdata = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic line(input logic [10:0] n, input logic [10:0] fw, input logic exp);
        @(posedge clock);
        trs.lineStb <= 1'b1;
        trs.lineNum <= n;
        trs.fwLine <= fw;
        @(posedge clock);
        trs.lineStb <= 1'b0;
        #1 chk(32'(lnErr), 32'(exp), "line error");
    endtask

    task automatic mark(input logic [6:0] v);
        @(posedge clock);
        {trs.sav, trs.eav, trs.trsBad, trs.fwSav, trs.fwEav} <= v[6:2];
        @(posedge clock);
        {trs.sav, trs.eav, trs.trsBad, trs.fwSav, trs.fwEav} <= 5'h00;
        #1 chk(32'({savErr, eavErr}), 32'(v[1:0]), "marker errors");
    endtask

    task automatic anc(input logic ch, input logic [9:0] w, input logic last);
        @(posedge clock);
        if (ch) luma <= '{1'b1, last, w};
        else chroma <= '{1'b1, last, w};
        @(posedge clock);
        luma.valid <= 1'b0;
        chroma.valid <= 1'b0;
    endtask

    task automatic rdc(input int slow, input logic [9:0] ea, input logic [2:0] el, string w);
        rm.pop(slow);
        #1 chk(32'(aux), 32'(ea), w);
        chk(32'(lvl), 32'(el), w);
    endtask

    // hang guard: far beyond the few hundred cycles the sequence needs
    initial begin
        #500000;
        fails++;
        summarize();
    end

    initial begin
        logic [9:0] b;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        #1 chk(32'(lvl), 32'h1, "reset level");
        chk(32'({lvlOe, auxOe}), 32'h0, "reset drive");
        chk(32'({lnErr, savErr, eavErr, ycsErr, ccsErr}), 32'h0, "reset flags");
        endTest("reset");

        line(11'h001, 11'h001, 1'b0);
        line(11'h002, 11'h002, 1'b0);
        line(11'h003, 11'h003, 1'b0);
        line(11'h007, 11'h007, 1'b1);
        line(11'h005, 11'h005, 1'b1);
        line(11'h006, 11'h006, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h1);
        line(11'h007, 11'h009, 1'b1);
        line(11'h008, 11'h008, 1'b0);
        apb(1'b1, MASK_OFS, 32'h1);
        repeat (2) @(posedge clock);
        #1 chk(32'(irq), 32'h1, "irq raised");
        apb(1'b1, STATUS_OFS, 32'h1);
        repeat (2) @(posedge clock);
        #1 chk(32'(irq), 32'h0, "irq cleared");
        apb(1'b1, MASK_OFS, 32'h0);
        endTest("line numbers");

        for (int i = 0; i < 7; i++) mark(tbl[i]);
        apb(1'b1, CTRL_OFS, 32'h0);
        endTest("markers");

        for (int c = 0; c < 2; c++) begin
            b = c ? 10'h000 : 10'h010;
            for (int k = 1; k <= 3; k++) anc(c[0], b + 10'(k), 1'b0);
            anc(c[0], 10'h200 | 10'(3 * b + 6), 1'b1);
            #1 chk(32'(c ? ycsErr : ccsErr), 32'h0, "checksum good");
            anc(c[0], b + 10'h005, 1'b0);
            anc(c[0], 10'h100 | (b + 10'h005), 1'b1);
            #1 chk(32'(c ? ycsErr : ccsErr), 32'h1, "checksum bad");
        end
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rdata, 32'h1E, "status events");
        apb(1'b1, STATUS_OFS, 32'h18);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rdata, 32'h06, "status after clear");
        endTest("checksums");

        rm.setup(1'b1, 1'b0);
        chk(32'({lvlOe, auxOe, lvl}), 32'h1B, "luma level driven");
        for (int i = 0; i < 6; i++)
            rdc(i % 2, lw[i], i == 0 ? 3'h3 : (i == 5 ? 3'h1 : 3'h2), "luma read");
        rdc(0, 10'h105, 3'h0, "underrun");
        apb(1'b0, LEVEL_OFS, 32'h0);
        chk(rdata, 32'h3, "level register");
        rm.setup(1'b0, 1'b0);
        chk(32'(lvl), 32'h3, "chroma level");
        rdc(1, 10'h011, 3'h3, "chroma read");
        rm.setup(1'b0, 1'b1);
        chk(32'({lvlOe, auxOe}), 32'h0, "outputs floated");
        rm.pop(0);
        rm.setup(1'b0, 1'b0);
        rdc(0, 10'h013, 3'h2, "read while floated");
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        chk(rdata, 32'h0, "unmapped data");
        endTest("fifo read");

        @(posedge clock);
        fifoResetN <= 1'b0;
        @(posedge clock);
        fifoResetN <= 1'b1;
        apb(1'b0, LEVEL_OFS, 32'h0);
        chk(rdata, 32'h11, "after fifo reset");
        for (int i = 1; i <= D + 1; i++) begin
            anc(1'b0, 10'(i), 1'b0);
            if (i == D / 2 || i == AF || i == D || i == D + 1) begin
                @(posedge clock);
                #1 chk(32'(lvl), i > D ? 32'h7 : (i == D ? 32'h6 : (i == AF ? 32'h5 : 32'h4)),
                       "fill level");
            end
        end
        apb(1'b1, MASK_OFS, 32'h40);
        repeat (2) @(posedge clock);
        #1 chk(32'(irq), 32'h1, "overrun irq");
        apb(1'b1, MASK_OFS, 32'h0);
        repeat (2) @(posedge clock);
        #1 chk(32'(irq), 32'h0, "irq masked");
        endTest("fill");
        summarize();
    end
endmodule // dfs_deformatter_status_bench
